/* hdl/apfg_pkg.sv */
package apfg_pkg;

   // Auxiliary pin function selection
   typedef enum logic [2:0] {
      APFG_FN_DRIVER_EN,
      APFG_FN_CHARGE_HI,
      APFG_FN_CHARGE_LO,
      APFG_FN_S2H_LED,
      APFG_FN_H2S_LED,
      APFG_FN_BOTH_LED
   } apfg_fn_e;

   localparam apfg_fn_e APFG_FN_RESET = APFG_FN_DRIVER_EN;

   // Timing base
   localparam int unsigned APFG_CLK_HZ      = 40_000_000;
   localparam int unsigned APFG_MAX_BAUD    = 3_000_000;
   localparam int unsigned APFG_MIN_BIT_CYC = (APFG_CLK_HZ + APFG_MAX_BAUD - 1) / APFG_MAX_BAUD;
   localparam int unsigned APFG_DIV_W       = 16;
   localparam logic [15:0] APFG_DIV_RESET   = 16'h0015;

   // Wishbone register map
   localparam logic [7:0] APFG_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] APFG_STATUS_ADDR = 8'h04;
   localparam logic [7:0] APFG_DIV_ADDR    = 8'h08;
   localparam int unsigned APFG_CTRL_FN_LSB = 0;
   localparam int unsigned APFG_STAT_PIN    = 0;
   localparam int unsigned APFG_STAT_DCP    = 1;
   localparam int unsigned APFG_STAT_SUSP   = 2;
   localparam int unsigned APFG_STAT_TXB    = 3;

   // Transmitter activity flags
   typedef struct packed {
      logic char_pending;
      logic start_bit;
      logic stop_bit;
   } apfg_tx_s;

endpackage : apfg_pkg

/* hdl/apfg_aux_pin.sv */
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Driver enable rises one bit period before each start bit.
// - Driver enable falls when the stop bit begins; timing is fixed.
// - Driver enable stays low while no character is sent.
// - Recognise attachment to a dedicated charging port.
// - A dedicated charging port leaves device unenumerated and suspended.
// - Charge detect goes active once port detected and suspended.
// - Charge detect exists in active-high and active-low forms.
// - Enumerated, unsuspended device holds charge detect inactive.
// - Three LED selections: serial-to-host, host-to-serial, combined.
// - Serial-to-host LED shows receive traffic forwarded to host.
// - Host-to-serial LED shows host data sent on transmit line.
// - Combined LED shows traffic in either direction.
// - Bit rate at most 3 Mbaud; lead count uses the divider clamped to that minimum, while the divider register keeps its written value.
// - Pin defaults to driver enable function.
module apfg_aux_pin
   import apfg_pkg::*;
#(
   parameter int unsigned DIV_W = APFG_DIV_W
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Configuration from nonvolatile store
   input  wire logic [2:0]  cfg_function,
   // Transmitter side, same clock
   input  wire apfg_tx_s    tx_status,
   // Receiver and USB side, same clock
   input  wire logic        rx_active,
   input  wire logic        data_lines_shorted,
   input  wire logic        usb_suspended,
   input  wire logic        usb_enumerated,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Auxiliary pin
   output logic             aux_pin0
);

   ////////////////////////////////////////////////////////////////////////////
   apfg_fn_e         fn_r;
   logic             fn_loaded_r;
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] lead_cnt_r;
   logic             line_driver_enable_r;
   logic             dedicated_charge_port_r;
   logic             aux_pin0_r;
   logic             aux_pin0_nxt;
   logic             wb_req;
   logic             addr_ok;
   logic             in_lead_r;

   function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
      if (d < DIV_W'(APFG_MIN_BIT_CYC)) begin
         return DIV_W'(APFG_MIN_BIT_CYC);
      end
      return d;
   endfunction : clamp_div

   function automatic apfg_fn_e decode_fn(input logic [2:0] c);
      if (c > 3'h5) begin
         return APFG_FN_RESET;
      end
      return apfg_fn_e'(c);
   endfunction : decode_fn

   ////////////////////////////////////////////////////////////////////////////
   // Function latched once after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fn_r        <= APFG_FN_RESET;
         fn_loaded_r <= 1'b0;
      end else if (!fn_loaded_r) begin
         fn_r        <= decode_fn(cfg_function);
         fn_loaded_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Driver enable: lead count one bit period before start bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line_driver_enable_r <= 1'b0;
         lead_cnt_r           <= '0;
         in_lead_r            <= 1'b0;
      end else if (tx_status.stop_bit || !tx_status.char_pending) begin
         line_driver_enable_r <= 1'b0;
         lead_cnt_r           <= '0;
         in_lead_r            <= 1'b0;
      end else if (!line_driver_enable_r) begin
         line_driver_enable_r <= 1'b1;
         lead_cnt_r           <= clamp_div(div_r) - DIV_W'(1);
         in_lead_r            <= 1'b1;
      end else if (in_lead_r) begin
         if (lead_cnt_r != '0) begin
            lead_cnt_r <= lead_cnt_r - DIV_W'(1);
         end else begin
            in_lead_r <= 1'b0;
         end
      end
   end

   // Lead time elapsed flag, only read back as status bit APFG_STAT_TXB
   logic tx_go;
   assign tx_go = line_driver_enable_r && in_lead_r && (lead_cnt_r == '0);

   ////////////////////////////////////////////////////////////////////////////
   // Charging port detection
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dedicated_charge_port_r <= 1'b0;
      end else if (usb_enumerated) begin
         dedicated_charge_port_r <= 1'b0;
      end else if (data_lines_shorted) begin
         dedicated_charge_port_r <= 1'b1;
      end
   end

   logic charge_active;
   assign charge_active = dedicated_charge_port_r && usb_suspended
                          && !usb_enumerated;

   ////////////////////////////////////////////////////////////////////////////
   // Pin multiplexer
   always_comb begin
      aux_pin0_nxt = 1'b0;
      unique case (fn_r)
         APFG_FN_DRIVER_EN: aux_pin0_nxt = line_driver_enable_r;
         APFG_FN_CHARGE_HI: aux_pin0_nxt = charge_active;
         APFG_FN_CHARGE_LO: aux_pin0_nxt = !charge_active;
         APFG_FN_S2H_LED:   aux_pin0_nxt = !rx_active;
         APFG_FN_H2S_LED:   aux_pin0_nxt = !tx_status.char_pending;
         APFG_FN_BOTH_LED:  aux_pin0_nxt = !(rx_active || tx_status.char_pending);
         default:           aux_pin0_nxt = line_driver_enable_r;
      endcase
   end

   // Driver enable path bypasses the flop so the lead is exact
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aux_pin0_r <= 1'b0;
      end else begin
         aux_pin0_r <= aux_pin0_nxt;
      end
   end

   assign aux_pin0 = (fn_r == APFG_FN_DRIVER_EN) ? line_driver_enable_r : aux_pin0_r;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave, one wait state
   assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign addr_ok = (wb_adr_i == APFG_CTRL_ADDR) || (wb_adr_i == APFG_STATUS_ADDR)
                    || (wb_adr_i == APFG_DIV_ADDR);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req && addr_ok;
         wb_err_o <= wb_req && !addr_ok;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               APFG_CTRL_ADDR:   wb_dat_o[APFG_CTRL_FN_LSB +: 3] <= 3'(fn_r);
               APFG_STATUS_ADDR: begin
                  wb_dat_o[APFG_STAT_PIN]  <= aux_pin0;
                  wb_dat_o[APFG_STAT_DCP]  <= dedicated_charge_port_r;
                  wb_dat_o[APFG_STAT_SUSP] <= usb_suspended;
                  wb_dat_o[APFG_STAT_TXB]  <= tx_go;
               end
               APFG_DIV_ADDR:    wb_dat_o[DIV_W-1:0] <= div_r;
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Bit period divider; function select is read-only
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_r <= DIV_W'(APFG_DIV_RESET);
      end else if (wb_req && wb_we_i && wb_adr_i == APFG_DIV_ADDR) begin
         if (wb_sel_i[0]) div_r[7:0]  <= wb_dat_i[7:0];
         if (wb_sel_i[1]) div_r[DIV_W-1:8] <= wb_dat_i[DIV_W-1:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_lead_low_idle: assert property (@(posedge clk) disable iff (!resetn)
      !tx_status.char_pending |=> !line_driver_enable_r)
      else $error("driver enable active while idle");
   chk_stop_release: assert property (@(posedge clk) disable iff (!resetn)
      tx_status.stop_bit |=> !line_driver_enable_r)
      else $error("driver enable not released at stop bit");
   chk_lead_rise: assert property (@(posedge clk) disable iff (!resetn)
      $rose(line_driver_enable_r) |-> in_lead_r && lead_cnt_r == clamp_div(div_r) - DIV_W'(1))
      else $error("lead count wrong");
   chk_lead_ready: assert property (@(posedge clk) disable iff (!resetn)
      $rose(line_driver_enable_r) && clamp_div(div_r) == DIV_W'(APFG_MIN_BIT_CYC)
      |-> ##13 (tx_go || !line_driver_enable_r))
      else $error("lead time not at minimum bit period");
   chk_charge_off_enum: assert property (@(posedge clk) disable iff (!resetn)
      usb_enumerated && fn_r == APFG_FN_CHARGE_HI |=> !aux_pin0)
      else $error("charge detect active while enumerated");
   chk_charge_on: assert property (@(posedge clk) disable iff (!resetn)
      fn_r == APFG_FN_CHARGE_LO && charge_active |=> !aux_pin0)
      else $error("active-low charge detect not low");
   chk_led_low: assert property (@(posedge clk) disable iff (!resetn)
      fn_r == APFG_FN_BOTH_LED && rx_active |=> !aux_pin0)
      else $error("combined led not on");
   chk_fn_stable: assert property (@(posedge clk) disable iff (!resetn)
      fn_loaded_r |=> $stable(fn_r))
      else $error("function changed after latch");

endmodule : apfg_aux_pin

/* dv/apfg_far_side.sv */
`timescale 1ns/10ps
module apfg_far_side (
   // Pin from the device
   input  wire logic aux_pin0,
   // Load kind: high for an LED sinking into the pin
   input  wire logic led_load,
   // What the far side sees as active
   output logic      active
);
   // LED lights while pin is low, others act on a high pin
   assign active = led_load ? ~aux_pin0 : aux_pin0;
endmodule : apfg_far_side

/* dv/aux_pin_function_generator_test.sv */
`timescale 1ns/10ps
module aux_pin_function_generator_test;
   import apfg_pkg::*;
   logic        clk, resetn, led_load, rx_active, data_lines_shorted;
   logic        usb_suspended, usb_enumerated, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [2:0]  cfg_function;
   apfg_tx_s    tx_status;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic        wb_ack_o, wb_err_o, aux_pin0, lit, ack, err;
   int          num_errors, num_checks;

   apfg_aux_pin dut (.clk, .resetn, .cfg_function, .tx_status, .rx_active,
      .data_lines_shorted, .usb_suspended, .usb_enumerated, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
      .aux_pin0);
   apfg_far_side far (.aux_pin0(aux_pin0), .led_load(led_load), .active(lit));

   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic finish_test;
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : idle

   // Reset with a new function code, all activity inputs quiet
   task automatic start(input logic [2:0] fn);
      @(posedge clk);
      resetn             <= 1'b0;
      cfg_function       <= fn;
      tx_status          <= '0;
      rx_active          <= 1'b0;
      data_lines_shorted <= 1'b0;
      usb_suspended      <= 1'b0;
      usb_enumerated     <= 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      idle(2);
   endtask : start

   // Classic single cycle, held until ack or err seen at a falling edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(negedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         $display("[ERR] %0t bus answer timeout", $time);
      end
      @(posedge clk);
      ack = wb_ack_o;
      err = wb_err_o;
      rd  = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end

   initial begin
      {resetn, led_load, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      num_errors = 0;
      num_checks = 0;
      start(3'h0);
      chk(lit, 1'b0, "enable not idle");
      wb(1'b0, APFG_CTRL_ADDR, '0);
      chk(rd[2:0], 3'h0, "default function");
      wb(1'b0, APFG_DIV_ADDR, '0);
      chk(rd, 32'h0000_0015, "divider reset");
      wb(1'b1, APFG_DIV_ADDR, 32'h0000_0003);
      wb(1'b0, APFG_DIV_ADDR, '0);
      chk(rd, 32'h0000_0003, "divider write");
      wb(1'b0, 8'h0C, '0);
      chk({ack, err}, 2'b01, "unmapped answer");
      cfg_function       <= 3'h1;
      data_lines_shorted <= 1'b1;
      usb_suspended      <= 1'b1;
      idle(3);
      chk(lit, 1'b0, "function changed after latch");
      @(posedge clk);
      data_lines_shorted <= 1'b0;
      usb_suspended      <= 1'b0;
      tx_status.char_pending <= 1'b1;
      idle(1);
      chk(lit, 1'b1, "enable lead");
      // Lead clamped to 14 cycles although divider holds 3
      idle(12);
      wb(1'b0, APFG_STATUS_ADDR, '0);
      chk(rd[APFG_STAT_TXB], 1'b1, "start bit time");
      chk(lit, 1'b1, "enable before stop");
      tx_status.stop_bit <= 1'b1;
      idle(1);
      chk(lit, 1'b0, "enable at stop bit");
      @(posedge clk);
      tx_status <= '0;
      idle(3);
      chk(lit, 1'b0, "enable after char");
      for (int fn = 1; fn <= 2; fn++) begin
         start(fn[2:0]);
         chk(lit, fn == 2, "charge idle");
         @(posedge clk);
         data_lines_shorted <= 1'b1;
         usb_suspended      <= 1'b1;
         idle(3);
         chk(lit, fn == 1, "charge active");
         wb(1'b0, APFG_STATUS_ADDR, '0);
         chk(rd[APFG_STAT_DCP], 1'b1, "port detect");
         usb_enumerated     <= 1'b1;
         usb_suspended      <= 1'b0;
         data_lines_shorted <= 1'b0;
         idle(3);
         chk(lit, fn == 2, "charge on host");
      end
      led_load <= 1'b1;
      for (int fn = 3; fn <= 5; fn++) begin
         start(fn[2:0]);
         chk(lit, 1'b0, "led idle");
         @(posedge clk);
         rx_active <= 1'b1;
         idle(3);
         chk(lit, fn != 4, "receive led");
         @(posedge clk);
         rx_active <= 1'b0;
         tx_status.char_pending <= 1'b1;
         idle(3);
         chk(lit, fn != 3, "transmit led");
         @(posedge clk);
         tx_status.char_pending <= 1'b0;
         idle(3);
         chk(lit, 1'b0, "led off");
      end
      finish_test();
   end
endmodule : aux_pin_function_generator_test
